// [design/iofd_flag_decoder.sv]
// Control flag decoder for the serial front end: power state, buffer fill, threshold select.
// Assumes bytes arrive already deserialised on the core clock; the data line comes raw from the pin.
//
// Operation
// RULE_01 - two-wire 0x00 clears buffer address counter
// RULE_02 - sleep flag enters sleep, ignores line
// RULE_03 - sleep entry clears all volatile state
// RULE_04 - idle flag enters idle, ignores line
// RULE_05 - idle keeps key store and seed
// RULE_06 - command flag appends data sequentially
// RULE_07 - host sends only defined flag values
// RULE_08 - wake leaves low power, restarts watchdog
// RULE_09 - active threshold follows stored address bit 3
// RULE_10 - flag is byte zero, data follows
// RULE_11 - host idle sequence: address, 0x02, stop
// RULE_12 - watchdog expiry forces sleep regardless
// RULE_13 - flag decoded by active link's table
`timescale 1ns/10ps
module iofd_flag_decoder
   import iofd_pkg::*;
#(
   parameter int BUF_DEPTH = BUF_DEPTH_DEF,
   parameter int WDOG_LIMIT = WDOG_CYCLES,
   parameter int WAKE_LOW = WAKE_LOW_CYCLES
) (
   input wire logic clk_in, // Core clock, 100 MHz.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic link_sel_in, // 0 two-wire, 1 single-wire.
   input iofd_byte_type rx_byte_in, // Received byte of an input block.
   input wire logic sda_in, // Raw data line level, for wake detection.
   input wire logic [7:0] addr_cfg_in, // Stored bus address configuration byte.
   output iofd_bufwr_type buf_wr_out, // Write into the input command buffer.
   output iofd_pwr_type pwr_state_out, // Present power state.
   output logic volatile_clear_out, // Pulse clearing all volatile state.
   output logic key_retain_out, // High while key store and seed must hold.
   output logic input_threshold_track_sel_out, // High: thresholds track supply.
   output logic [BUF_AW-1:0] buf_addr_out // Buffer address counter.
);

   initial begin
      if (BUF_DEPTH < 1 || BUF_DEPTH > (1 << BUF_AW)) $error("iofd_flag_decoder: bad BUF_DEPTH");
      if (WAKE_LOW < 2 || WAKE_LOW >= (1 << WAKE_CNT_W)) $error("iofd_flag_decoder: bad WAKE_LOW");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      iofd_pwr_type pwr;
      logic sda_meta;
      logic sda_sync;
      logic in_cmd;
      logic [BUF_AW-1:0] addr;
      logic full;
      iofd_bufwr_type bw;
      logic clr;
      logic restart;
      logic [WAKE_CNT_W-1:0] wake_cnt;
   } iofd_state_type;

   iofd_state_type st_reg;
   iofd_state_type st_next;
   iofd_flag_type flag;
   logic wdog_expire;

   // Maps a flag byte through the table of the link carrying it.
   function automatic iofd_flag_type decode_flag(input logic [7:0] b, input logic link);
      iofd_flag_type f;
      f = FLG_RSVD;
      if (link == LINK_TWO_WIRE) begin
         case (b)
            TW_FLAG_RESET: f = FLG_RESET;
            TW_FLAG_SLEEP: f = FLG_SLEEP;
            TW_FLAG_IDLE: f = FLG_IDLE;
            TW_FLAG_CMD: f = FLG_CMD;
            default: f = FLG_RSVD;
         endcase
      end else begin
         case (b)
            SW_FLAG_SLEEP: f = FLG_SLEEP;
            SW_FLAG_IDLE: f = FLG_IDLE;
            SW_FLAG_CMD: f = FLG_CMD;
            default: f = FLG_RSVD;
         endcase
      end
      return f;
   endfunction : decode_flag

   assign flag = decode_flag(rx_byte_in.data, link_sel_in); // see RULE_13

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   // It counts only in cycles that stay active, so an expiry never lands after a flag has left active.
   iofd_watchdog #(
      .LIMIT(WDOG_LIMIT)
   ) u_wdog (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .restart_in(st_reg.restart),
      .run_in((st_reg.pwr == PWR_ACTIVE) && (st_next.pwr == PWR_ACTIVE)),
      .expire_out(wdog_expire)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Reserved flags open no block, so their data bytes are dropped.
   always_comb begin
      st_next = st_reg;
      st_next.bw.wr = 1'b0;
      st_next.clr = 1'b0;
      st_next.restart = 1'b0;
      st_next.sda_meta = sda_in;
      st_next.sda_sync = st_reg.sda_meta;
      case (st_reg.pwr)
         PWR_ACTIVE: begin
            st_next.wake_cnt = '0;
            if (wdog_expire) begin
               st_next.pwr = PWR_SLEEP; // see RULE_12
               st_next.clr = 1'b1;
               st_next.addr = ADDR_RESET;
               st_next.full = 1'b0;
               st_next.in_cmd = 1'b0;
            end else if (rx_byte_in.valid && rx_byte_in.first) begin
               st_next.in_cmd = 1'b0; // see RULE_10
               case (flag)
                  FLG_RESET: begin
                     st_next.addr = ADDR_RESET; // see RULE_01
                     st_next.full = 1'b0;
                  end
                  FLG_SLEEP: begin
                     st_next.pwr = PWR_SLEEP; // see RULE_02
                     st_next.clr = 1'b1; // see RULE_03
                     st_next.addr = ADDR_RESET;
                     st_next.full = 1'b0;
                  end
                  FLG_IDLE: st_next.pwr = PWR_IDLE; // see RULE_04
                  FLG_CMD: st_next.in_cmd = 1'b1;
                  default: st_next.in_cmd = 1'b0;
               endcase
            end else if (rx_byte_in.valid && st_reg.in_cmd && !st_reg.full) begin
               // The full flag stops writes, as a full-size buffer leaves the counter no spare count.
               st_next.bw.wr = 1'b1; // see RULE_06
               st_next.bw.addr = st_reg.addr;
               st_next.bw.data = rx_byte_in.data;
               st_next.addr = st_reg.addr + 1'b1;
               st_next.full = (int'(st_reg.addr) == BUF_DEPTH - 1);
            end
         end
         PWR_SLEEP, PWR_IDLE: begin
            // Bytes are ignored here; only a long low level on the line wakes.
            st_next.in_cmd = 1'b0;
            if (st_reg.sda_sync) begin
               st_next.wake_cnt = '0;
            end else if (int'(st_reg.wake_cnt) == WAKE_LOW - 1) begin
               st_next.pwr = PWR_ACTIVE; // see RULE_08
               st_next.restart = 1'b1;
               st_next.wake_cnt = '0;
            end else begin
               st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
            end
         end
         default: st_next.pwr = PWR_SLEEP;
      endcase
   end

   // State register.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_reg <= '{pwr: PWR_SLEEP, sda_meta: SDA_IDLE_LEVEL, sda_sync: SDA_IDLE_LEVEL,
                     addr: ADDR_RESET, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign buf_wr_out = st_reg.bw;
   assign pwr_state_out = st_reg.pwr;
   assign volatile_clear_out = st_reg.clr;
   assign buf_addr_out = st_reg.addr;
   assign key_retain_out = (st_reg.pwr != PWR_SLEEP); // see RULE_05
   assign input_threshold_track_sel_out = (st_reg.pwr == PWR_ACTIVE) && addr_cfg_in[THRESH_SEL_BIT]; // see RULE_09

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence flag_seen(logic [7:0] v, logic l);
      pwr_state_out == PWR_ACTIVE && !wdog_expire && rx_byte_in.valid && rx_byte_in.first
         && rx_byte_in.data == v && link_sel_in == l;
   endsequence

   addr_reset_a: assert property (flag_seen(8'h00, 1'b0) |=> buf_addr_out == 7'h00) // see RULE_01
      else $error("reset flag did not clear address");
   sleep_entry_a: assert property (flag_seen(8'hCC, 1'b1) |=> pwr_state_out == PWR_SLEEP
      && volatile_clear_out ##1 !volatile_clear_out) // see RULE_02
      else $error("single-wire sleep not taken");
   sleep_clear_a: assert property ($rose(volatile_clear_out) |-> pwr_state_out == PWR_SLEEP
      && buf_addr_out == 7'h00 && !key_retain_out) // see RULE_03
      else $error("sleep without full clear");
   idle_entry_a: assert property (flag_seen(8'h02, 1'b0) |=> pwr_state_out == PWR_IDLE) // see RULE_04
      else $error("idle flag not taken");
   idle_keep_a: assert property (pwr_state_out == PWR_IDLE |-> key_retain_out && !volatile_clear_out) // see RULE_05
      else $error("idle lost retained state");
   cmd_fill_a: assert property (buf_wr_out.wr |-> buf_addr_out == buf_wr_out.addr + 1'b1
      && $past(st_reg.in_cmd)) // see RULE_06
      else $error("command byte not written in sequence");
   asleep_deaf_a: assert property (pwr_state_out != PWR_ACTIVE |=> !buf_wr_out.wr
      && $stable(buf_addr_out)) // see RULE_02
      else $error("line activity acted on while asleep");
   wake_exit_a: assert property (pwr_state_out != PWR_ACTIVE ##1 pwr_state_out == PWR_ACTIVE
      |-> st_reg.restart ##1 !st_reg.restart) // see RULE_08
      else $error("wake without watchdog restart");
   thresh_sel_a: assert property (pwr_state_out != PWR_ACTIVE |-> !input_threshold_track_sel_out) // see RULE_09
      else $error("threshold select outside active");
   wdog_sleep_a: assert property (wdog_expire |=> pwr_state_out == PWR_SLEEP && volatile_clear_out) // see RULE_12
      else $error("watchdog expiry did not sleep");
   link_table_a: assert property (flag_seen(8'h01, 1'b1) |=> pwr_state_out == PWR_ACTIVE) // see RULE_13
      else $error("two-wire code honoured on single wire");

   sleep_cover_c: cover property (flag_seen(8'h01, 1'b0) ##1 pwr_state_out == PWR_SLEEP);
   idle_cover_c: cover property (flag_seen(8'hBB, 1'b1) ##1 pwr_state_out == PWR_IDLE);
   fill_cover_c: cover property (buf_wr_out.wr ##1 buf_wr_out.wr);
   wake_cover_c: cover property (pwr_state_out == PWR_IDLE ##1 pwr_state_out == PWR_ACTIVE);

endmodule : iofd_flag_decoder

// [design/iofd_watchdog.sv]
// Watchdog counter that forces the decoder to sleep a fixed time after wake.
// Assumes restart_in pulses on each wake and run_in is high only while active.
`timescale 1ns/10ps
module iofd_watchdog
   import iofd_pkg::*;
#(
   parameter int LIMIT = WDOG_CYCLES
) (
   input wire logic clk_in, // Core clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic restart_in, // Restart the count from zero.
   input wire logic run_in, // Count while high.
   output logic expire_out // One-cycle pulse when the interval ends.
);

   initial begin
      if (LIMIT < 2) $error("iofd_watchdog: LIMIT must be at least 2");
   end

   typedef struct packed {
      logic [31:0] cnt;
      logic expire;
   } iofd_wdog_type;

   iofd_wdog_type wdog_reg;
   iofd_wdog_type wdog_next;

   // The count clears on a wake restart and again at each expiry.
   always_comb begin
      wdog_next = wdog_reg;
      wdog_next.expire = 1'b0;
      if (restart_in) begin
         wdog_next.cnt = '0; // see RULE_08
      end else if (run_in) begin
         if (wdog_reg.cnt == 32'(LIMIT - 1)) begin
            wdog_next.expire = 1'b1; // see RULE_12
            wdog_next.cnt = '0;
         end else begin
            wdog_next.cnt = wdog_reg.cnt + 32'h00000001;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wdog_reg <= '0;
      end else begin
         wdog_reg <= wdog_next;
      end
   end

   assign expire_out = wdog_reg.expire;

   restart_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      restart_in |=> wdog_reg.cnt == 32'h00000000) else $error("watchdog not restarted"); // see RULE_08

endmodule : iofd_watchdog

// [shared/iofd_pkg.sv]
// Package for the I/O control flag decoder: flag codes, timing constants and carrier types.
// Assumes a 100 MHz core clock shared by the decoder and its serial front end.
package iofd_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 100;
   // Watchdog interval from wake, in milliseconds.
   localparam int WDOG_TIME_MS = 1300;
   localparam int WDOG_CYCLES = WDOG_TIME_MS * 1000 * CLK_FREQ_MHZ;
   // Least low time on the data line that counts as a wake, in microseconds.
   localparam int WAKE_LOW_US = 60;
   localparam int WAKE_LOW_CYCLES = WAKE_LOW_US * CLK_FREQ_MHZ;
   localparam int WAKE_CNT_W = 16;

   // ----------------------------------------------------------------
   // Flag encodings per link
   // ----------------------------------------------------------------
   localparam logic [7:0] TW_FLAG_RESET = 8'h00;
   localparam logic [7:0] TW_FLAG_SLEEP = 8'h01;
   localparam logic [7:0] TW_FLAG_IDLE = 8'h02;
   localparam logic [7:0] TW_FLAG_CMD = 8'h03;
   localparam logic [7:0] SW_FLAG_SLEEP = 8'hCC;
   localparam logic [7:0] SW_FLAG_IDLE = 8'hBB;
   localparam logic [7:0] SW_FLAG_CMD = 8'h77;
   // Link select values.
   localparam logic LINK_TWO_WIRE = 1'b0;
   localparam logic LINK_SINGLE_WIRE = 1'b1;
   // Position of the threshold select bit in the stored bus address byte.
   localparam int THRESH_SEL_BIT = 3;

   // ----------------------------------------------------------------
   // Buffer and reset values
   // ----------------------------------------------------------------
   localparam int BUF_AW = 7;
   localparam int BUF_DEPTH_DEF = 128;
   localparam logic [BUF_AW-1:0] ADDR_RESET = 7'h00;
   localparam logic SDA_IDLE_LEVEL = 1'b1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PWR_SLEEP, PWR_IDLE, PWR_ACTIVE} iofd_pwr_type;
   typedef enum logic [2:0] {FLG_RESET, FLG_SLEEP, FLG_IDLE, FLG_CMD, FLG_RSVD} iofd_flag_type;

   // One received byte of an input block.
   typedef struct packed {
      logic valid;
      logic first;
      logic [7:0] data;
   } iofd_byte_type;

   // One write into the input command buffer.
   typedef struct packed {
      logic wr;
      logic [BUF_AW-1:0] addr;
      logic [7:0] data;
   } iofd_bufwr_type;

endpackage : iofd_pkg

// [tb/iofd_flag_decoder_tb.sv]
// Self-checking bench for the control flag decoder with a host model on its input.
// Assumes shortened watchdog, wake and buffer counts set by the parameters below.
`timescale 1ns/10ps
module iofd_flag_decoder_tb;
   import iofd_pkg::*;
   localparam int WD = 200;
   localparam int WL = 8;
   localparam int BD = 16;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic link = 1'b0;
   logic [7:0] cfg = 8'h00;
   iofd_byte_type rx_byte;
   logic sda;
   iofd_bufwr_type buf_wr_out;
   iofd_pwr_type pwr_state_out;
   logic volatile_clear_out;
   logic key_retain_out;
   logic input_threshold_track_sel_out;
   logic [BUF_AW-1:0] buf_addr_out;
   int errors = 0;
   int n_checks = 0;
   int exp_addr = 0;
   integer seed = 32'h222D;
   logic [BUF_AW+7:0] exp_q [$];
   logic [BUF_AW+7:0] exp_w;

   // ----------------------------------------------------------------
   // Clock, instances
   // ----------------------------------------------------------------
   always #5 clk_in = ~clk_in;

   iofd_host_model i_host (.clk_in(clk_in), .rx_byte_out(rx_byte), .sda_out(sda));

   iofd_flag_decoder #(.BUF_DEPTH(BD), .WDOG_LIMIT(WD), .WAKE_LOW(WL)) i_dut (
      .clk_in(clk_in), .resetn_in(resetn_in), .link_sel_in(link), .rx_byte_in(rx_byte),
      .sda_in(sda), .addr_cfg_in(cfg), .buf_wr_out(buf_wr_out), .pwr_state_out(pwr_state_out),
      .volatile_clear_out(volatile_clear_out), .key_retain_out(key_retain_out),
      .input_threshold_track_sel_out(input_threshold_track_sel_out), .buf_addr_out(buf_addr_out));

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask : chk

   // Every buffer write must match the oldest noted one; looked at mid-cycle while it stands.
   always @(negedge clk_in) begin
      if (resetn_in && buf_wr_out.wr === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "unexpected buffer write");
         end else begin
            exp_w = exp_q.pop_front();
            chk({buf_wr_out.addr, buf_wr_out.data} === exp_w, "buffer write");
         end
      end
   end

   // Releases the bus, checks the settled outputs, then returns on an edge.
   task automatic check_state(input iofd_pwr_type p, input logic c);
      i_host.release_bus();
      #1;
      chk(pwr_state_out === p, "power state");
      chk(buf_addr_out === BUF_AW'(exp_addr), "buffer address");
      chk(volatile_clear_out === c, "clear pulse");
      chk(key_retain_out === (p != PWR_SLEEP), "key retain");
      chk(input_threshold_track_sel_out === (p == PWR_ACTIVE && cfg[THRESH_SEL_BIT]), "threshold");
      @(posedge clk_in);
   endtask : check_state

   // Command block of n random bytes; writes beyond the buffer are dropped.
   task automatic cmd_block(input int n);
      logic [7:0] d;
      i_host.send_byte(1'b1, i_host.flag_code(link, 2'h3));
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         if (exp_addr < BD) begin
            exp_q.push_back({BUF_AW'(exp_addr), d});
            exp_addr++;
         end
         i_host.send_byte(1'b0, d);
      end
      check_state(PWR_ACTIVE, 1'b0);
   endtask : cmd_block

   // Flag followed by one data byte that must not be written.
   task automatic flag_and_byte(input logic [7:0] f, input iofd_pwr_type p, input logic c);
      i_host.send_byte(1'b1, f);
      i_host.send_byte(1'b0, 8'($random(seed)));
      check_state(p, c);
   endtask : flag_and_byte

   task automatic finish_test();
      if (exp_q.size() != 0) begin
         errors++;
         $display("FAIL %0t missing buffer writes", $time);
      end
      if (errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Watchdog against a hung run.
   initial begin
      #100000;
      errors++;
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      check_state(PWR_SLEEP, 1'b0);
      i_host.wake_line(WL - 3);
      check_state(PWR_SLEEP, 1'b0);
      for (int l = 0; l < 2; l++) begin
         link <= l[0];
         // Random byte, but the threshold bit takes both values over the two passes.
         cfg <= (8'($random(seed)) & 8'hF7) | (l[0] ? 8'h08 : 8'h00);
         i_host.wake_line(WL + 6);
         check_state(PWR_ACTIVE, 1'b0);
         cmd_block(4);
         cmd_block(3);
         if (l == 0) begin
            exp_addr = 0;
         end
         flag_and_byte(i_host.flag_code(link, 2'h0), PWR_ACTIVE, 1'b0);
         flag_and_byte(8'h5A, PWR_ACTIVE, 1'b0);
         flag_and_byte((l == 0) ? SW_FLAG_SLEEP : TW_FLAG_SLEEP, PWR_ACTIVE, 1'b0);
         i_host.send_byte(1'b1, i_host.flag_code(link, 2'h2));
         check_state(PWR_IDLE, 1'b0);
         flag_and_byte(i_host.flag_code(link, 2'h3), PWR_IDLE, 1'b0);
         i_host.wake_line(WL + 6);
         check_state(PWR_ACTIVE, 1'b0);
         cmd_block(BD + 2);
         i_host.send_byte(1'b1, i_host.flag_code(link, 2'h1));
         exp_addr = 0;
         check_state(PWR_SLEEP, 1'b1);
         flag_and_byte(i_host.flag_code(link, 2'h3), PWR_SLEEP, 1'b0);
      end
      i_host.wake_line(WL + 6);
      repeat (WD - 30) @(posedge clk_in);
      check_state(PWR_ACTIVE, 1'b0);
      repeat (40) @(posedge clk_in);
      check_state(PWR_SLEEP, 1'b0);
      finish_test();
   end
endmodule : iofd_flag_decoder_tb

// [tb/iofd_host_model.sv]
// Host model: sends input blocks and drives the data line of the flag decoder.
// Assumes its tasks are called at a rising clock edge; the data line is pulled up.
`timescale 1ns/10ps
module iofd_host_model
   import iofd_pkg::*;
(
   input wire logic clk_in, // Core clock.
   output iofd_byte_type rx_byte_out, // Byte towards the decoder.
   output logic sda_out // Data line level.
);
   // The bus starts released and the line idles high.
   initial begin
      rx_byte_out = '0;
      sda_out = 1'b1;
   end

   // Flag code per link: kind 0 reset on two-wire (0x00 on single-wire, no reset there), 1 sleep, 2 idle, 3 command.
   function automatic logic [7:0] flag_code(input logic link, input logic [1:0] kind);
      if (link == LINK_TWO_WIRE) begin
         return {6'h00, kind};
      end
      case (kind)
         2'h1: return SW_FLAG_SLEEP;
         2'h2: return SW_FLAG_IDLE;
         2'h3: return SW_FLAG_CMD;
         default: return 8'h00;
      endcase
   endfunction : flag_code

   // One byte per cycle; first marks the flag in byte zero.
   task automatic send_byte(input logic first, input logic [7:0] data);
      rx_byte_out <= {1'b1, first, data};
      @(posedge clk_in);
   endtask : send_byte

   // Released bus clears valid and first and shows inverted data, so stale bytes never look valid.
   task automatic release_bus();
      rx_byte_out <= {2'b00, ~rx_byte_out.data};
   endtask : release_bus

   // Holds the line low for n cycles, then lets it go back high.
   task automatic wake_line(input int n);
      sda_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      sda_out <= 1'b1;
      @(posedge clk_in);
   endtask : wake_line
endmodule : iofd_host_model
